// ===== rcsc_pkg.sv
// Package: constants and carrier types for the regulator and clock control
package rcsc_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [15:0] RCSC_ADDR_REG_CTL   = 16'h7004;
  localparam logic [15:0] RCSC_ADDR_PCG_A     = 16'h7010;
  localparam logic [15:0] RCSC_ADDR_PCG_B     = 16'h7011;
  localparam logic [15:0] RCSC_ADDR_PRST_CNT  = 16'h7012;
  localparam logic [15:0] RCSC_ADDR_PRST_CTL  = 16'h7013;
  localparam logic [15:0] RCSC_ADDR_IDLE_CFG  = 16'h7014;
  localparam logic [15:0] RCSC_ADDR_USB_SYS   = 16'h7015;
  localparam logic [15:0] RCSC_ADDR_STATUS    = 16'h7016;
  localparam logic [15:0] RCSC_ADDR_BOOT_CTL  = 16'h7017;
  localparam logic [15:0] RCSC_RTC_LO         = 16'h1900;
  localparam logic [15:0] RCSC_RTC_HI         = 16'h197F;
  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int unsigned RCSC_BIT_USB_EN     = 0;
  localparam int unsigned RCSC_BIT_CORE_VSEL  = 1;
  localparam int unsigned RCSC_BIT_OSC_DIS    = 0;
  localparam int unsigned RCSC_BIT_BIAS_DIS   = 1;
  localparam int unsigned RCSC_BIT_USB_BOOT   = 0;
  localparam int unsigned RCSC_BIT_HANDOFF    = 1;
  localparam int unsigned RCSC_IDLE_CPU_BIT   = 0;
  localparam logic [15:0] RCSC_RST_ZERO       = 16'h0000;
  localparam logic [15:0] RCSC_RST_ONES       = 16'hFFFF;
  localparam logic [15:0] RCSC_USB_SYS_RST    = 16'h0003;
  localparam logic [15:0] RCSC_IDLE_ALL       = 16'hFFFE;
  localparam logic        RCSC_VSEL_1V3       = 1'b0;
  // ---------------------------------------------------------------
  // Clock generator settings
  // ---------------------------------------------------------------
  localparam logic [10:0] RCSC_MULT_RTC_BOOT  = 11'h177;  // 375x
  localparam logic [10:0] RCSC_MULT_RTC_USB   = 11'h465;  // 1125x
  localparam logic [10:0] RCSC_MULT_EXT_USB   = 11'h003;  // 3x
  localparam logic [10:0] RCSC_MULT_ONE       = 11'h001;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    RCSC_CK_RTC_PLL = 2'h0,
    RCSC_CK_EXT_BYP = 2'h1,
    RCSC_CK_RTC_USB = 2'h2,
    RCSC_CK_EXT_USB = 2'h3
  } rcsc_ck_e;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } rcsc_bus_s;
  typedef struct packed {
    logic analog_on;
    logic core_on;
    logic usb_on;
    logic core_vsel;
  } rcsc_reg_s;
  typedef struct packed {
    logic        bypass;
    logic        ref_rtc;
    logic [10:0] mult;
  } rcsc_clk_s;
endpackage : rcsc_pkg

// ===== rcsc_top.sv
// Regulator enables, core voltage select and system clock source control
`timescale 1ns/1ps
//
// Overview of operation
// [RQ1] Control register bits 15..2 read zero; writes to them are dropped.
// [RQ2] Control bit 1 picks core regulator level: 0 is 1.3 V, 1 is 1.05 V.
// [RQ3] Control bit 0 enables USB regulator; off means its output floats.
// [RQ4] Either power-down bit kills all; else analog on, core by pin, USB by bit.
// [RQ5] Clock reference is external pin or RTC oscillator per select pin.
// [RQ6] Board holds the reference select pin static after reset.
// [RQ7] RTC address range is refused while the RTC oscillator is off.
// [RQ8] Select low after reset: generator runs RTC clock times 375.
// [RQ9] Select high: generator bypassed, system clock taken from external pin.
// [RQ10] During USB boot the generator is set near 36 MHz.
// [RQ11] Boot register setup leaves clock frequency and first timer alone.
// [RQ12] Hardware reset turns every peripheral clock off.
// [RQ13] At handoff peripheral clocks off and all non-CPU domains idled.
// [RQ14] Gating registers drive peripheral clocks, reset registers their resets.
// [RQ15] Software clears both USB oscillator disable bits to start it.
// [RQ16] Software waits for USB oscillator settling, up to 10 ms.
// [RQ17] After power-down, regulators return only on wake, alarm or RTC cycle.
// [RQ18] Core regulator voltage select resets to the 1.3 V setting.
module rcsc_top (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                nrst_i,
  // Register port
  input  wire rcsc_pkg::rcsc_bus_s bus_i,
  output logic              [15:0] rdata_o,
  output logic                     rtc_sel_o,
  // Static pins and RTC-domain levels
  input  wire logic                ref_clk_select_i,
  input  wire logic                core_regulator_disable_pin_i,
  input  wire logic                rtc_osc_running_i,
  input  wire logic                bandgap_powerdown_i,
  input  wire logic                regulator_powerdown_i,
  input  wire logic                wake_pin_i,
  input  wire logic                rtc_alarm_i,
  // Regulator controls
  output rcsc_pkg::rcsc_reg_s      regulator_o,
  // Clock generator controls
  output rcsc_pkg::rcsc_clk_s      clkgen_o,
  // Peripheral clocks, resets, idle domains and USB oscillator
  output logic              [31:0] periph_clk_en_o,
  output logic              [15:0] periph_rst_o,
  output logic              [15:0] idle_domains_o,
  output logic                     usb_osc_enable_o
);
  import rcsc_pkg::*;

  // ---------------------------------------------------------------
  // Reset release and input synchronisers
  // ---------------------------------------------------------------
  logic       rst_meta_ff;
  logic       rst_n;
  logic [6:0] sync_meta_ff;
  logic [6:0] sync_ff;
  logic [1:0] sync_fill_ff;
  wire  [6:0] raw_in = {rtc_alarm_i, wake_pin_i, regulator_powerdown_i,
                        bandgap_powerdown_i, rtc_osc_running_i,
                        core_regulator_disable_pin_i, ref_clk_select_i};

  // Release reset through two stages
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta_ff <= 1'b0;
      rst_n       <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n       <= rst_meta_ff;
    end
  end

  // Pins arrive from outside the clock domain
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sync_meta_ff <= 7'h00;
      sync_ff      <= 7'h00;
      sync_fill_ff <= 2'h0;
    end else begin
      sync_meta_ff <= raw_in;
      sync_ff      <= sync_meta_ff;
      // High once sync_ff holds real pin levels, not reset zeros
      sync_fill_ff <= {sync_fill_ff[0], 1'b1};
    end
  end

  wire s_sel   = sync_ff[0];
  wire s_cdis  = sync_ff[1];
  wire s_rtcok = sync_ff[2];
  wire s_bgpd  = sync_ff[3];
  wire s_ldopd = sync_ff[4];
  wire s_wake  = sync_ff[5];
  wire s_alarm = sync_ff[6];

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  wire in_rtc   = (bus_i.addr >= RCSC_RTC_LO) && (bus_i.addr <= RCSC_RTC_HI);
  wire rtc_ok   = in_rtc && s_rtcok;                          // [RQ7]
  wire wr_ctl   = bus_i.wr && (bus_i.addr == RCSC_ADDR_REG_CTL);
  wire wr_pcga  = bus_i.wr && (bus_i.addr == RCSC_ADDR_PCG_A);
  wire wr_pcgb  = bus_i.wr && (bus_i.addr == RCSC_ADDR_PCG_B);
  wire wr_prcnt = bus_i.wr && (bus_i.addr == RCSC_ADDR_PRST_CNT);
  wire wr_prctl = bus_i.wr && (bus_i.addr == RCSC_ADDR_PRST_CTL);
  wire wr_idle  = bus_i.wr && (bus_i.addr == RCSC_ADDR_IDLE_CFG);
  wire wr_usb   = bus_i.wr && (bus_i.addr == RCSC_ADDR_USB_SYS);
  wire wr_boot  = bus_i.wr && (bus_i.addr == RCSC_ADDR_BOOT_CTL);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [1:0]  ctl_ff;
  logic [15:0] pcga_ff;
  logic [15:0] pcgb_ff;
  logic [15:0] prcnt_ff;
  logic [15:0] prctl_ff;
  logic [15:0] idle_ff;
  logic [1:0]  usbsys_ff;
  logic [1:0]  boot_ff;
  logic        pd_latch_ff;
  logic        clk_sel_ff;
  logic        sel_taken_ff;

  // Only bits 1..0 exist; upper write data is dropped          [RQ1]
  wire [1:0] nxt_ctl = wr_ctl ? bus_i.wdata[1:0] : ctl_ff;
  // Handoff forces clocks off and idles all but the CPU domain
  wire handoff = wr_boot && bus_i.wdata[RCSC_BIT_HANDOFF];    // [RQ13]

  // Control and USB system registers
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctl_ff    <= {RCSC_VSEL_1V3, 1'b0};                     // [RQ18]
      usbsys_ff <= RCSC_USB_SYS_RST[1:0];
      boot_ff   <= 2'h0;
    end else begin
      ctl_ff    <= nxt_ctl;                                   // [RQ2] [RQ3]
      usbsys_ff <= wr_usb ? bus_i.wdata[1:0] : usbsys_ff;
      boot_ff   <= wr_boot ? bus_i.wdata[1:0] : boot_ff;
    end
  end

  // Peripheral gating, reset and idle registers
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pcga_ff  <= RCSC_RST_ZERO;                              // [RQ12]
      pcgb_ff  <= RCSC_RST_ZERO;                              // [RQ12]
      prcnt_ff <= RCSC_RST_ZERO;
      prctl_ff <= RCSC_RST_ZERO;
      idle_ff  <= RCSC_RST_ZERO;
    end else begin
      pcga_ff  <= handoff ? RCSC_RST_ZERO :
                  (wr_pcga ? bus_i.wdata : pcga_ff);          // [RQ14]
      pcgb_ff  <= handoff ? RCSC_RST_ZERO :
                  (wr_pcgb ? bus_i.wdata : pcgb_ff);          // [RQ14]
      prcnt_ff <= wr_prcnt ? bus_i.wdata : prcnt_ff;
      prctl_ff <= wr_prctl ? bus_i.wdata : prctl_ff;          // [RQ14]
      idle_ff  <= handoff ? RCSC_IDLE_ALL :
                  (wr_idle ? bus_i.wdata : idle_ff);          // [RQ13]
    end
  end

  // ---------------------------------------------------------------
  // Power-down latch: a pulse on either bit keeps regulators off
  // until a wake, an alarm, or RTC supply cycling (reset) clears it
  // ---------------------------------------------------------------
  wire pd_req   = s_bgpd || s_ldopd;
  wire pd_wake  = s_wake || s_alarm;
  // Power-down request wins over a wake in the same cycle
  wire nxt_pd   = pd_req || (pd_latch_ff && !pd_wake);        // [RQ17]

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pd_latch_ff <= 1'b0;
    end else begin
      pd_latch_ff <= nxt_pd;
    end
  end

  // Regulator enables from the controls matrix
  rcsc_reg_s nxt_reg;
  assign nxt_reg.analog_on = !nxt_pd;                         // [RQ4]
  assign nxt_reg.core_on   = !nxt_pd && !s_cdis;              // [RQ4]
  assign nxt_reg.usb_on    = !nxt_pd && nxt_ctl[RCSC_BIT_USB_EN]; // [RQ3]
  assign nxt_reg.core_vsel = nxt_ctl[RCSC_BIT_CORE_VSEL];     // [RQ2]

  // ---------------------------------------------------------------
  // Clock source: select pin caught once after reset release, since
  // the board keeps it static and later changes are not followed
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      clk_sel_ff   <= 1'b0;
      sel_taken_ff <= 1'b0;
    end else begin
      // Capture only after the synchroniser has filled
      sel_taken_ff <= sel_taken_ff || sync_fill_ff[1];
      clk_sel_ff   <= sel_taken_ff ? clk_sel_ff : s_sel;      // [RQ6]
    end
  end

  wire usb_boot = boot_ff[RCSC_BIT_USB_BOOT];
  rcsc_ck_e ck_mode;
  assign ck_mode = rcsc_ck_e'({usb_boot, clk_sel_ff});

  rcsc_clk_s nxt_clk;
  always_comb begin
    nxt_clk = '{bypass: 1'b0, ref_rtc: 1'b1, mult: RCSC_MULT_RTC_BOOT};
    case (ck_mode)
      RCSC_CK_RTC_PLL: begin
        nxt_clk.mult = RCSC_MULT_RTC_BOOT;                    // [RQ5] [RQ8]
      end
      RCSC_CK_EXT_BYP: begin
        nxt_clk = '{bypass: 1'b1, ref_rtc: 1'b0, mult: RCSC_MULT_ONE}; // [RQ9]
      end
      RCSC_CK_RTC_USB: begin
        nxt_clk.mult = RCSC_MULT_RTC_USB;                     // [RQ10]
      end
      RCSC_CK_EXT_USB: begin
        nxt_clk = '{bypass: 1'b0, ref_rtc: 1'b0, mult: RCSC_MULT_EXT_USB}; // [RQ10]
      end
      default: begin
        nxt_clk = '{bypass: 1'b0, ref_rtc: 1'b1, mult: RCSC_MULT_RTC_BOOT};
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Read mux: one-cycle read data, unmapped reads return zero
  // ---------------------------------------------------------------
  logic [15:0] rd_mux;
  always_comb begin
    case (bus_i.addr)
      RCSC_ADDR_REG_CTL:  rd_mux = {14'h0000, ctl_ff};        // [RQ1]
      RCSC_ADDR_PCG_A:    rd_mux = pcga_ff;
      RCSC_ADDR_PCG_B:    rd_mux = pcgb_ff;
      RCSC_ADDR_PRST_CNT: rd_mux = prcnt_ff;
      RCSC_ADDR_PRST_CTL: rd_mux = prctl_ff;
      RCSC_ADDR_IDLE_CFG: rd_mux = idle_ff;
      RCSC_ADDR_USB_SYS:  rd_mux = {14'h0000, usbsys_ff};
      RCSC_ADDR_BOOT_CTL: rd_mux = {14'h0000, boot_ff};
      RCSC_ADDR_STATUS:   rd_mux = {10'h000, clk_sel_ff, pd_latch_ff,
                                     regulator_o};
      default:            rd_mux = RCSC_RST_ZERO;
    endcase
  end

  // Output registers
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o          <= RCSC_RST_ZERO;
      rtc_sel_o        <= 1'b0;
      regulator_o      <= '0;
      clkgen_o         <= '{bypass: 1'b0, ref_rtc: 1'b1,
                            mult: RCSC_MULT_ONE};
      periph_clk_en_o  <= 32'h0000_0000;                      // [RQ12]
      periph_rst_o     <= RCSC_RST_ZERO;
      idle_domains_o   <= RCSC_RST_ZERO;
      usb_osc_enable_o <= 1'b0;
    end else begin
      rdata_o          <= bus_i.rd ? rd_mux : RCSC_RST_ZERO;
      rtc_sel_o        <= (bus_i.rd || bus_i.wr) && rtc_ok;   // [RQ7]
      regulator_o      <= nxt_reg;
      clkgen_o         <= sel_taken_ff ? nxt_clk : clkgen_o;
      periph_clk_en_o  <= {pcgb_ff, pcga_ff};                 // [RQ14]
      periph_rst_o     <= prctl_ff;                           // [RQ14]
      idle_domains_o   <= idle_ff;
      usb_osc_enable_o <= !usbsys_ff[RCSC_BIT_OSC_DIS] &&
                          !usbsys_ff[RCSC_BIT_BIAS_DIS];      // [RQ15]
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_ctl_read;
    bus_i.rd && bus_i.addr == RCSC_ADDR_REG_CTL;
  endsequence

  AST_CTL_UPPER_ZERO: assert property (@(posedge clk_i) disable iff (!rst_n)
    s_ctl_read |=> rdata_o[15:2] == 14'h0000)                  // [RQ1]
    else $error("control upper bits not zero");
  AST_VSEL_FOLLOWS: assert property (@(posedge clk_i) disable iff (!rst_n)
    wr_ctl |=> regulator_o.core_vsel == $past(bus_i.wdata[1]))  // [RQ2]
    else $error("core voltage select did not follow write");
  AST_USB_OFF: assert property (@(posedge clk_i) disable iff (!rst_n)
    (wr_ctl && !bus_i.wdata[0]) |=> !regulator_o.usb_on)       // [RQ3]
    else $error("usb regulator on while disabled");
  AST_PD_ALL_OFF: assert property (@(posedge clk_i) disable iff (!rst_n)
    pd_req |=> !regulator_o.analog_on && !regulator_o.core_on
               && !regulator_o.usb_on)                         // [RQ4]
    else $error("regulator on during power-down");
  AST_RTC_BLOCK: assert property (@(posedge clk_i) disable iff (!rst_n)
    ((bus_i.rd || bus_i.wr) && in_rtc && !s_rtcok) |=> !rtc_sel_o) // [RQ7]
    else $error("rtc range reached with oscillator off");
  AST_HANDOFF: assert property (@(posedge clk_i) disable iff (!rst_n)
    (handoff && !wr_idle) |=> ##1 periph_clk_en_o == 32'h0000_0000
      && idle_domains_o[RCSC_IDLE_CPU_BIT] == 1'b0)            // [RQ13]
    else $error("handoff left clocks on or cpu idled");
  AST_PD_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n)
    (pd_latch_ff && !pd_wake && !pd_req) |=> pd_latch_ff)      // [RQ17]
    else $error("regulators left power-down without wake");
  AST_USB_OSC: assert property (@(posedge clk_i) disable iff (!rst_n)
    (wr_usb && bus_i.wdata[1:0] == 2'h0) ##1 !wr_usb
    |=> usb_osc_enable_o)                                      // [RQ15]
    else $error("usb oscillator not started");
  AST_BYPASS: assert property (@(posedge clk_i) disable iff (!rst_n)
    (sel_taken_ff && ck_mode == RCSC_CK_EXT_BYP) |=> clkgen_o.bypass) // [RQ9]
    else $error("external mode not bypassed");

  // No power-down pending and none latched
  sequence s_pd_clear;
    !pd_req && !pd_latch_ff;
  endsequence

  AST_ANALOG_ON: assert property (@(posedge clk_i) disable iff (!rst_n)
    s_pd_clear |=> regulator_o.analog_on)                      // [RQ4]
    else $error("analog regulator off without power-down");
  AST_CORE_PIN: assert property (@(posedge clk_i) disable iff (!rst_n)
    s_cdis |=> !regulator_o.core_on)                           // [RQ4]
    else $error("core regulator on with disable pin high");
  AST_USB_ON: assert property (@(posedge clk_i) disable iff (!rst_n)
    (wr_ctl && bus_i.wdata[0] && !pd_req && !pd_latch_ff)
    |=> regulator_o.usb_on)                                    // [RQ3]
    else $error("usb regulator off while enabled");
  AST_SEL_STATIC: assert property (@(posedge clk_i) disable iff (!rst_n)
    sel_taken_ff |=> $stable(clk_sel_ff))                      // [RQ6]
    else $error("clock select changed after capture");
  AST_PLL_MULT: assert property (@(posedge clk_i) disable iff (!rst_n)
    (sel_taken_ff && ck_mode == RCSC_CK_RTC_PLL)
    |=> clkgen_o.ref_rtc && clkgen_o.mult == RCSC_MULT_RTC_BOOT) // [RQ8]
    else $error("rtc reference not at boot multiplier");
  AST_USB_MULT: assert property (@(posedge clk_i) disable iff (!rst_n)
    (sel_taken_ff && ck_mode == RCSC_CK_RTC_USB)
    |=> clkgen_o.ref_rtc && clkgen_o.mult == RCSC_MULT_RTC_USB) // [RQ10]
    else $error("usb boot multiplier wrong on rtc reference");
  AST_EXT_USB: assert property (@(posedge clk_i) disable iff (!rst_n)
    (sel_taken_ff && ck_mode == RCSC_CK_EXT_USB)
    |=> !clkgen_o.bypass && clkgen_o.mult == RCSC_MULT_EXT_USB) // [RQ10]
    else $error("usb boot multiplier wrong on external pin");
  AST_GATING: assert property (@(posedge clk_i) disable iff (!rst_n)
    wr_pcga |=> ##1 periph_clk_en_o[15:0] == $past(bus_i.wdata, 2)) // [RQ14]
    else $error("gating register not driving clocks");
  AST_PRST: assert property (@(posedge clk_i) disable iff (!rst_n)
    wr_prctl |=> ##1 periph_rst_o == $past(bus_i.wdata, 2))    // [RQ14]
    else $error("reset control register not driving resets");
  AST_RESET_STATE: assert property (@(posedge clk_i) disable iff (!rst_n)
    $rose(rst_n) |-> periph_clk_en_o == 32'h0000_0000
      && regulator_o.core_vsel == RCSC_VSEL_1V3)               // [RQ12] [RQ18]
    else $error("reset left clocks on or voltage select set");
  AST_RTC_OPEN: assert property (@(posedge clk_i) disable iff (!rst_n)
    ((bus_i.rd || bus_i.wr) && in_rtc && s_rtcok) |=> rtc_sel_o) // [RQ7]
    else $error("rtc range not selected with oscillator on");
  AST_RDATA_IDLE: assert property (@(posedge clk_i) disable iff (!rst_n)
    !bus_i.rd |=> rdata_o == RCSC_RST_ZERO)
    else $error("read data not zero outside a read");
endmodule : rcsc_top

// ===== rcsc_tb_top.sv
// Self-checking testbench for the regulator and clock source control
`timescale 1ns/1ps
module rcsc_tb_top;
  import rcsc_pkg::*;
  // ------------------------------------------------------------
  // Stimulus and observation signals
  // ------------------------------------------------------------
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  rcsc_bus_s   bus_i = '0;
  logic        ref_clk_select_i = 1'b0;
  logic        core_regulator_disable_pin_i = 1'b0;
  logic        rtc_osc_running_i = 1'b0;
  logic        bandgap_powerdown_i = 1'b0;
  logic        regulator_powerdown_i = 1'b0;
  logic        wake_pin_i = 1'b0;
  logic        rtc_alarm_i = 1'b0;
  logic [15:0] rdata_o;
  logic        rtc_sel_o;
  rcsc_reg_s   regulator_o;
  rcsc_clk_s   clkgen_o;
  logic [31:0] periph_clk_en_o;
  logic [15:0] periph_rst_o;
  logic [15:0] idle_domains_o;
  logic        usb_osc_enable_o;
  int          n_errors = 0;
  int          n_checks = 0;
  logic [15:0] rd_val;
  logic        rd_sel;
  // ------------------------------------------------------------
  // Clock and device under test
  // ------------------------------------------------------------
  // 50 MHz clock
  always #10 clk_i = ~clk_i;
  rcsc_top u_rcsc_top (
    .clk_i                        (clk_i),
    .nrst_i                       (nrst_i),
    .bus_i                        (bus_i),
    .rdata_o                      (rdata_o),
    .rtc_sel_o                    (rtc_sel_o),
    .ref_clk_select_i             (ref_clk_select_i),
    .core_regulator_disable_pin_i (core_regulator_disable_pin_i),
    .rtc_osc_running_i            (rtc_osc_running_i),
    .bandgap_powerdown_i          (bandgap_powerdown_i),
    .regulator_powerdown_i        (regulator_powerdown_i),
    .wake_pin_i                   (wake_pin_i),
    .rtc_alarm_i                  (rtc_alarm_i),
    .regulator_o                  (regulator_o),
    .clkgen_o                     (clkgen_o),
    .periph_clk_en_o              (periph_clk_en_o),
    .periph_rst_o                 (periph_rst_o),
    .idle_domains_o               (idle_domains_o),
    .usb_osc_enable_o             (usb_osc_enable_o)
  );
  // ------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------
  // Compare and count; case inequality so unknowns never match
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One-cycle write strobe, launched just after an edge
  task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_i);
    bus_i.addr  <= a;
    bus_i.wdata <= d;
    bus_i.wr    <= 1'b1;
    @(posedge clk_i);
    bus_i.wr    <= 1'b0;
  endtask : reg_wr
  // Read data and range select stand only in the cycle after the strobe
  task automatic reg_rd(input logic [15:0] a, output logic [15:0] d,
                        output logic s);
    @(posedge clk_i);
    bus_i.addr <= a;
    bus_i.rd   <= 1'b1;
    @(posedge clk_i);
    bus_i.rd   <= 1'b0;
    #1;
    d = rdata_o;
    s = rtc_sel_o;
  endtask : reg_rd
  // Covers pin synchronisers plus the output register stage
  task automatic settle();
    repeat (6) @(posedge clk_i);
    #1;
  endtask : settle
  // Reset held ten cycles; select pin is sampled just after release
  task automatic do_reset(input logic sel);
    @(posedge clk_i);
    nrst_i           <= 1'b0;
    ref_clk_select_i <= sel;
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    #1;
  endtask : do_reset
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    chk("regulators", regulator_o, 4'hC);
    chk("periph_clk", periph_clk_en_o, 32'h0);
    chk("clkgen", clkgen_o, {2'b01, RCSC_MULT_RTC_BOOT});
    reg_rd(RCSC_ADDR_REG_CTL, rd_val, rd_sel);
    chk("ctl_reset", rd_val, 16'h0000);
    $display("test reset done");
  endtask : t_reset
  // Reserved bits, voltage select, and the regulator matrix
  task automatic t_ctl();
    reg_wr(RCSC_ADDR_REG_CTL, 16'hFFFF);
    reg_rd(RCSC_ADDR_REG_CTL, rd_val, rd_sel);
    chk("ctl_read", rd_val, 16'h0003);
    settle();
    chk("reg_vsel_usb", regulator_o, 4'hF);
    for (int i = 0; i < 4; i++) begin
      core_regulator_disable_pin_i <= i[1];
      reg_wr(RCSC_ADDR_REG_CTL, {15'h0, i[0]});
      settle();
      chk("matrix", regulator_o, {1'b1, ~i[1], i[0], 1'b0});
    end
    core_regulator_disable_pin_i <= 1'b0;
    $display("test control done");
  endtask : t_ctl
  // Power-down holds until a wake source; first by wake, then by alarm
  task automatic t_pd();
    reg_wr(RCSC_ADDR_REG_CTL, 16'h0001);
    for (int k = 0; k < 2; k++) begin
      bandgap_powerdown_i   <= (k == 0);
      regulator_powerdown_i <= (k == 1);
      settle();
      chk("pd_off", regulator_o, 4'h0);
      reg_rd(RCSC_ADDR_STATUS, rd_val, rd_sel);
      chk("status_pd", rd_val, 16'h0010);
      bandgap_powerdown_i   <= 1'b0;
      regulator_powerdown_i <= 1'b0;
      settle();
      chk("pd_held", regulator_o, 4'h0);
      wake_pin_i  <= (k == 0);
      rtc_alarm_i <= (k == 1);
      settle();
      wake_pin_i  <= 1'b0;
      rtc_alarm_i <= 1'b0;
      settle();
      chk("pd_wake", regulator_o, 4'hE);
    end
    $display("test powerdown done");
  endtask : t_pd
  // RTC window edges, then refusal with the oscillator stopped
  task automatic t_rtc();
    logic [15:0] adr [4] = '{16'h1900, 16'h197F, 16'h18FF, 16'h1980};
    rtc_osc_running_i <= 1'b1;
    settle();
    for (int i = 0; i < 4; i++) begin
      reg_rd(adr[i], rd_val, rd_sel);
      chk("rtc_sel", rd_sel, (i < 2));
    end
    rtc_osc_running_i <= 1'b0;
    settle();
    reg_rd(RCSC_RTC_LO, rd_val, rd_sel);
    chk("rtc_off", rd_sel, 1'b0);
    $display("test rtc done");
  endtask : t_rtc
  // Gating, resets, USB boot clock and handoff
  // Setup writes touch no clock generator or timer state
  task automatic t_periph();
    reg_wr(RCSC_ADDR_PCG_A, 16'h1234);
    reg_wr(RCSC_ADDR_PCG_B, 16'hABCD);
    reg_wr(RCSC_ADDR_PRST_CTL, 16'h00FF);
    reg_wr(RCSC_ADDR_PRST_CNT, 16'h0055);
    reg_rd(RCSC_ADDR_PRST_CNT, rd_val, rd_sel);
    chk("prcnt", rd_val, 16'h0055);
    settle();
    chk("clk_en", periph_clk_en_o, 32'hABCD1234);
    chk("prst", periph_rst_o, 16'h00FF);
    reg_wr(RCSC_ADDR_BOOT_CTL, 16'h0001);
    settle();
    chk("usb_boot", clkgen_o, {2'b01, RCSC_MULT_RTC_USB});
    reg_wr(RCSC_ADDR_BOOT_CTL, 16'h0002);
    settle();
    chk("hand_clk", periph_clk_en_o, 32'h0);
    chk("hand_idle", idle_domains_o, 16'hFFFE);
    chk("after_usb", clkgen_o, {2'b01, RCSC_MULT_RTC_BOOT});
    $display("test peripheral done");
  endtask : t_periph
  // Oscillator runs only with both disable bits clear
  // No USB use follows the enable; settling wait is software's
  task automatic t_usbosc();
    for (int d = 3; d >= 0; d--) begin
      reg_wr(RCSC_ADDR_USB_SYS, d[15:0]);
      settle();
      chk("usb_osc", usb_osc_enable_o, (d == 0));
    end
    reg_rd(16'h7020, rd_val, rd_sel);
    chk("unmapped", rd_val, 16'h0000);
    $display("test usb oscillator done");
  endtask : t_usbosc
  // Select high bypasses; later pin changes are ignored
  task automatic t_select();
    do_reset(1'b1);
    chk("bypass", clkgen_o, {2'b10, RCSC_MULT_ONE});
    ref_clk_select_i <= 1'b0;
    settle();
    chk("sel_static", clkgen_o, {2'b10, RCSC_MULT_ONE});
    reg_wr(RCSC_ADDR_BOOT_CTL, 16'h0001);
    settle();
    chk("ext_usb", clkgen_o, {2'b00, RCSC_MULT_EXT_USB});
    $display("test clock select done");
  endtask : t_select
  // ------------------------------------------------------------
  // Verdict, sequence and watchdog
  // ------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    do_reset(1'b0);
    t_reset();
    t_ctl();
    t_pd();
    t_rtc();
    t_periph();
    t_usbosc();
    t_select();
    complete_run();
  end
  // Tests take well under a thousand cycles; allow five times that
  initial begin
    #(20 * 5000);
    n_errors++;
    complete_run();
  end
endmodule : rcsc_tb_top
